// file: logic/dmxs_pkg.sv
package dmxs_pkg;

  // Synchronization field codes of the channel control register.
  localparam logic [1:0] DMXS_SYNC_NONE = 2'h0;
  localparam logic [1:0] DMXS_SYNC_SRC = 2'h1;
  localparam logic [1:0] DMXS_SYNC_DST = 2'h2;

  // Bus states of one bus cycle.
  localparam logic [1:0] DMXS_T1 = 2'h0;
  localparam logic [1:0] DMXS_T2 = 2'h1;
  localparam logic [1:0] DMXS_T3 = 2'h2;
  localparam logic [1:0] DMXS_T4 = 2'h3;

  // Clocks from a request sample to the start of the fetch cycle.
  localparam int DMXS_LAT_CLKS = 4;
  localparam logic [1:0] DMXS_LAT_LAST = 2'(DMXS_LAT_CLKS - 2);

  // Least number of clocks the bus is released after a destination transfer.
  localparam int DMXS_GAP_CLKS = 2;
  localparam logic [1:0] DMXS_GAP_LAST = 2'(DMXS_GAP_CLKS - 1);

  localparam int DMXS_SYNC_STAGES = 3;

  typedef enum logic [4:0] {
    DMXS_IDLE = 5'h01,
    DMXS_LAT = 5'h02,
    DMXS_FETCH = 5'h04,
    DMXS_DEPOSIT = 5'h08,
    DMXS_GAP = 5'h10
  } dmxs_state_t;

  // Status of the channel on the processor bus.
  typedef struct packed {
    logic own;
    logic fetch;
    logic deposit;
    logic [1:0] bus_state;
    logic wait_state;
    logic periph_sel;
  } dmxs_bus_t;

  localparam dmxs_bus_t DMXS_BUS_IDLE = '0;

endpackage

// file: logic/dmxs_sync.sv
`timescale 1ns/10ps
module dmxs_sync (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Asynchronous level and its filtered copy.
  input wire logic async_i,
  output logic level_o
);
  import dmxs_pkg::*;

  logic [DMXS_SYNC_STAGES-1:0] stage_reg;

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[DMXS_SYNC_STAGES-2:0], async_i};
    end
  end

  // A change counts once the second and third stages agree.
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      level_o <= 1'b0;
    end else if (stage_reg[1] == stage_reg[2]) begin
      level_o <= stage_reg[2];
    end
  end

endmodule

// file: logic/dmxs_sequencer.sv
`timescale 1ns/10ps
// Overview of operation
// - Source- and destination-paced modes are chosen by the sync field and differ in which cycle selects the peripheral and when the request is sampled again.
// - Four clocks pass between sampling the request active and the start of the fetch cycle, plus one for each clock a CPU cycle holds the last latency clock.
// - In source-paced mode the fetch read selects the requesting peripheral.
// - In source-paced mode the request is sampled again at the start of the deposit cycle, allowing back to back transfers.
// - In destination-paced mode the deposit write selects the requesting peripheral.
// - After each destination-paced transfer the bus is released for at least two clocks before the next fetch.
// - During that release the CPU may run its own bus cycles.
// - With no CPU cycle in the gap exactly two idle clocks separate deposit end and next fetch.
// - Each deposit wait state delays the destination-paced sampling point by one clock.
// - The request pin is synchronized to the clock and sampled four clocks before a bus cycle would begin.
// - A request sampled active in idle always runs its transfer; one sampled in the gap can lapse under CPU cycles. An unsampled request is never stored.
// - Every transfer is a fetch followed by a deposit, abandoned only by reset.
module dmxs_sequencer (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Channel control.
  input wire logic chan_enable_i,
  input wire logic [1:0] sync_mode_i,
  // Peripheral side.
  input wire logic transfer_request_line_i,
  // Processor bus side.
  input wire logic bus_ready_i,
  input wire logic cpu_cycle_i,
  output dmxs_pkg::dmxs_bus_t bus_o,
  output logic xfer_done_o
);
  import dmxs_pkg::*;

  logic req_level;
  dmxs_state_t state_reg, state_next;
  logic [1:0] ph_reg, ph_next;
  logic [1:0] cnt_reg, cnt_next;
  logic src_mode_reg, src_mode_next;
  logic mode_ok;
  logic cycle_end;
  logic wait_now;
  dmxs_bus_t bus_next;

  dmxs_sync u_req_sync (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .async_i(transfer_request_line_i),
    .level_o(req_level)
  );

  assign mode_ok = chan_enable_i &&
      (sync_mode_i == DMXS_SYNC_SRC || sync_mode_i == DMXS_SYNC_DST);
  assign wait_now = (ph_reg == DMXS_T3) && !bus_ready_i;
  assign cycle_end = (ph_reg == DMXS_T4);

  always_comb begin
    state_next = state_reg;
    ph_next = ph_reg;
    cnt_next = cnt_reg;
    src_mode_next = src_mode_reg;
    case (state_reg)
      DMXS_IDLE: begin
        cnt_next = '0;
        if (mode_ok && req_level) begin
          state_next = DMXS_LAT;
          src_mode_next = (sync_mode_i == DMXS_SYNC_SRC);
        end
      end
      DMXS_LAT: begin
        // Sampled request runs even if the line drops now.
        if (cnt_reg == DMXS_LAT_LAST && !cpu_cycle_i) begin
          state_next = DMXS_FETCH;
          ph_next = DMXS_T1;
          cnt_next = '0;
        end else if (cnt_reg != DMXS_LAT_LAST) begin
          cnt_next = cnt_reg + 2'h1;
        end
      end
      DMXS_FETCH: begin
        if (!wait_now) begin
          ph_next = ph_reg + 2'h1;
        end
        if (cycle_end) begin
          state_next = DMXS_DEPOSIT;
          ph_next = DMXS_T1;
        end
      end
      DMXS_DEPOSIT: begin
        if (!wait_now) begin
          ph_next = ph_reg + 2'h1;
        end
        if (cycle_end) begin
          ph_next = DMXS_T1;
          cnt_next = '0;
          if (!src_mode_reg) begin
            state_next = DMXS_GAP;
          end else if (mode_ok && req_level) begin
            // The synchronizer lag puts the pin sample at deposit start.
            state_next = DMXS_FETCH;
          end else begin
            state_next = DMXS_IDLE;
          end
        end
      end
      DMXS_GAP: begin
        if (cnt_reg != DMXS_GAP_LAST) begin
          cnt_next = cnt_reg + 2'h1;
        end else if (!(mode_ok && req_level)) begin
          // The synchronizer lag puts the pin sample two clocks before
          // the end of the deposit cycle, wait states included.
          state_next = DMXS_IDLE;
        end else if (!cpu_cycle_i) begin
          state_next = DMXS_FETCH;
          ph_next = DMXS_T1;
        end
      end
      default: begin
        state_next = DMXS_IDLE;
        ph_next = DMXS_T1;
        cnt_next = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= DMXS_IDLE;
      ph_reg <= DMXS_T1;
      cnt_reg <= '0;
      src_mode_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ph_reg <= ph_next;
      cnt_reg <= cnt_next;
      src_mode_reg <= src_mode_next;
    end
  end

  always_comb begin
    bus_next = DMXS_BUS_IDLE;
    bus_next.bus_state = ph_next;
    bus_next.fetch = (state_next == DMXS_FETCH);
    bus_next.deposit = (state_next == DMXS_DEPOSIT);
    bus_next.own = bus_next.fetch || bus_next.deposit;
    bus_next.wait_state = bus_next.own && (ph_next == DMXS_T3) &&
        (ph_reg == DMXS_T3) && (state_next == state_reg);
    bus_next.periph_sel = (bus_next.fetch && src_mode_next) ||
        (bus_next.deposit && !src_mode_next);
    if (!bus_next.own) begin
      bus_next.bus_state = DMXS_T1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      bus_o <= DMXS_BUS_IDLE;
      xfer_done_o <= 1'b0;
    end else begin
      bus_o <= bus_next;
      xfer_done_o <= (state_reg == DMXS_DEPOSIT) && cycle_end;
    end
  end

endmodule

// file: dv/dmxs_sequencer_props.sv
`timescale 1ns/10ps
module dmxs_sequencer_props (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Watched ports.
  input wire logic chan_enable_i,
  input wire logic [1:0] sync_mode_i,
  input wire logic transfer_request_line_i,
  input wire logic bus_ready_i,
  input wire logic cpu_cycle_i,
  input wire dmxs_pkg::dmxs_bus_t bus_o,
  input wire logic xfer_done_o
);
  import dmxs_pkg::*;
  logic src, dst, f4, d4;
  assign src = sync_mode_i == DMXS_SYNC_SRC;
  assign dst = sync_mode_i == DMXS_SYNC_DST;
  assign f4 = bus_o.fetch && bus_o.bus_state == DMXS_T4;
  assign d4 = bus_o.deposit && bus_o.bus_state == DMXS_T4;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  a_fetch_deposit: assert property (f4 |=> bus_o.deposit
    && bus_o.bus_state == DMXS_T1) else $error("deposit missing");
  a_idle_quiet: assert property (!bus_o.own |->
    bus_o == DMXS_BUS_IDLE) else $error("idle bus not quiet");
  a_done_pulse: assert property (d4 |=> xfer_done_o
    ##1 !xfer_done_o) else $error("done pulse wrong");
  a_dst_release: assert property (d4 && dst |=> !bus_o.own [*2])
    else $error("bus not released");
  a_src_sel: assert property (bus_o.own && src |->
    bus_o.periph_sel == bus_o.fetch) else $error("source select");
  a_dst_sel: assert property (bus_o.own && dst |->
    bus_o.periph_sel == bus_o.deposit) else $error("dest select");
  a_wait_hold: assert property (bus_o.wait_state |->
    $past(bus_o.bus_state) == DMXS_T3 && !$past(bus_ready_i))
    else $error("wait state without stall");
  a_start_lat: assert property ($rose(bus_o.own) && src |->
    !$past(bus_o.own, 4)) else $error("start too early");
  cover property (d4 && src ##1 bus_o.fetch);
  cover property (d4 && dst ##1 !bus_o.own [*2] ##1 bus_o.fetch);
  cover property (bus_o.wait_state && bus_o.deposit);
  cover property (d4 && dst ##1 cpu_cycle_i);
endmodule
bind dmxs_sequencer dmxs_sequencer_props dmxs_sequencer_props_i (
  .sys_clk_i(sys_clk_i), .reset_i(reset_i), .chan_enable_i(chan_enable_i),
  .sync_mode_i(sync_mode_i), .bus_ready_i(bus_ready_i),
  .transfer_request_line_i(transfer_request_line_i), .bus_o(bus_o),
  .cpu_cycle_i(cpu_cycle_i), .xfer_done_o(xfer_done_o));

// file: dv/dmxs_periph.sv
`timescale 1ns/10ps
module dmxs_periph (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Bench control.
  input wire logic [7:0] want_i,
  input wire logic load_i,
  input wire logic [1:0] waits_i,
  // Bus view.
  input wire dmxs_pkg::dmxs_bus_t bus_i,
  output logic req_o,
  output logic ready_o
);
  import dmxs_pkg::*;
  logic [7:0] left_reg;
  logic [1:0] wait_reg;
  logic hit;
  assign hit = bus_i.periph_sel && bus_i.bus_state == DMXS_T3;
  assign req_o = left_reg != 8'h0;
  assign ready_o = !(hit && wait_reg != waits_i);
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i)
      left_reg <= 8'h0;
    else if (load_i)
      left_reg <= want_i;
    else if (bus_i.periph_sel && bus_i.bus_state == DMXS_T1 && req_o)
      left_reg <= left_reg - 8'h1;
  end
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i)
      wait_reg <= 2'h0;
    else
      wait_reg <= hit ? wait_reg + 2'h1 : 2'h0;
  end
endmodule

// file: dv/dmxs_sequencer_test.sv
`timescale 1ns/10ps
module dmxs_sequencer_test;
  import dmxs_pkg::*;
  logic sys_clk_i = 0, reset_i = 1, chan_enable_i = 0, cpu_cycle_i = 0;
  logic bus_ready_i, req, xfer_done_o, load = 0, c_on = 0;
  logic [1:0] sync_mode_i = 0, w = 0;
  logic [7:0] want = 0;
  dmxs_bus_t bus_o;
  int n_fail = 0, checks_done = 0, cyc = 0, last = 0, gap = 0, dones = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  dmxs_sequencer dmxs_sequencer_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .chan_enable_i(chan_enable_i), .sync_mode_i(sync_mode_i),
    .transfer_request_line_i(req), .bus_ready_i(bus_ready_i),
    .cpu_cycle_i(cpu_cycle_i), .bus_o(bus_o), .xfer_done_o(xfer_done_o));
  dmxs_periph dmxs_periph_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .want_i(want), .load_i(load), .waits_i(w), .bus_i(bus_o), .req_o(req),
    .ready_o(bus_ready_i));
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input string s, input int e, input int g);
    checks_done++;
    if (e != g) begin
      n_fail++;
      $display("[ERR] %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic cmpb(input dmxs_bus_t g);
    checks_done++;
    if (g !== DMXS_BUS_IDLE) begin
      n_fail++;
      $display("[ERR] bus_o expected %h seen %h", DMXS_BUS_IDLE, g);
    end
  endtask
  task automatic run(input logic e, input logic [1:0] m, input int n,
      input logic [1:0] ws, input logic c);
    gap = c ? 0 : (m == DMXS_SYNC_SRC ? 8 : 10) + ws;
    dones = 0;
    tick(1);
    chan_enable_i <= e;
    sync_mode_i <= m;
    w <= ws;
    c_on <= c;
    want <= 8'(n);
    load <= 1'b1;
    tick(1);
    load <= 1'b0;
    tick(20 * n + 40);
    cmp("transfers", (e && m inside {DMXS_SYNC_SRC, DMXS_SYNC_DST}) ? n : 0,
      dones);
  endtask
  always @(posedge sys_clk_i) begin
    cpu_cycle_i <= c_on && $urandom_range(0, 2) == 0;
    cyc++;
    if (xfer_done_o === 1'b1) begin
      if (dones > 0 && gap > 0)
        cmp("spacing", gap, cyc - last);
      last = cyc;
      dones++;
    end
    if (cyc == 6000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'he4a60fa6));
    tick(20);
    reset_i <= 1'b0;
    for (int m = 0; m < 4; m++)
      run(1'b1, 2'(m), 3, 2'h2, 1'b0);
    repeat (3)
      run(1'b1, DMXS_SYNC_SRC, 4, 2'($urandom_range(0, 3)), 1'b0);
    repeat (2)
      run(1'b1, DMXS_SYNC_DST, 3, 2'($urandom_range(2, 3)), 1'b0);
    run(1'b0, DMXS_SYNC_SRC, 2, 2'h0, 1'b0);
    run(1'b1, DMXS_SYNC_DST, 4, 2'h3, 1'b1);
    chan_enable_i <= 1'b1;
    want <= 8'h5;
    load <= 1'b1;
    tick(1);
    load <= 1'b0;
    tick(9);
    reset_i <= 1'b1;
    @(negedge sys_clk_i);
    cmpb(bus_o);
    tick(1);
    reset_i <= 1'b0;
    run(1'b1, DMXS_SYNC_SRC, 1, 2'h1, 1'b0);
    conclude();
  end
endmodule
